// ---- rtl/ucc_channel.sv ----
// Command, clock select and status logic of one asynchronous serial channel.
// Assumes the receiver, transmitter and counter/timer sit beside it on clk,
// and that the auxiliary pins arrive asynchronously.

module ucc_channel
   import ucc_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Register port
   input  wire logic [1:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // Auxiliary pins
   input  wire logic       aux_pin_two,
   input  wire logic       aux_pin_three,
   output logic            request_to_send_out_n,
   // Receiver side
   input  wire logic       wake_mode,
   input  wire logic       rx_xfer,
   input  wire logic [3:0] rx_load_err,
   input  wire logic       rx_queue_read,
   input  wire logic [3:0] rx_head_err,
   output logic            rx_active,
   output logic            rx_abort,
   output logic            rx_hunt,
   output logic            rx_reset,
   output logic      [3:0] rx_err_status,
   // Transmitter side
   input  wire logic       tx_idle,
   input  wire logic       tx_space_set,
   input  wire logic       tx_space_clr,
   input  wire logic       tx_underrun_set,
   input  wire logic       txq_wr_req,
   output logic            txq_wr_accept,
   output logic            tx_active,
   output logic            tx_space_available,
   output logic            tx_underrun_flag,
   // Counter/timer side
   input  wire logic       peer_timeout_xfer,
   input  wire logic       ct_16x_tick,
   output logic            ct_restart,
   output logic            ct_halt,
   output logic            ct_ready_clear,
   output logic            ct_force_counter,
   output logic            ct_startstop_block,
   output logic            mode_ptr_zero,
   // Baud clocks
   output logic            rx_clk_tick,
   output logic            rx_clk_is_1x,
   output logic            tx_clk_tick,
   output logic            tx_clk_is_1x
);

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic [UCC_ACC_BITS-1:0] rate_step(input logic grp, input logic set,
                                                         input logic [3:0] code);
      longint r;
      r = longint'(UCC_RATE_X10[{grp, set, code}]);
      rate_step = UCC_ACC_BITS'((r * 16 * (longint'(1) << UCC_ACC_BITS))
                                / (UCC_CLK_HZ * 10));
   endfunction

   function automatic logic is_table(input logic [3:0] code);
      is_table = (code < UCC_CS_TIMER);
   endfunction

   // ************************************************************
   // Register writes
   // ************************************************************
   logic       cmd_wr;
   logic [3:0] misc;
   logic [7:0] csel_reg;
   logic [7:0] aux_reg;

   assign cmd_wr = reg_wr && (reg_addr == UCC_OFS_CMD);
   assign misc   = cmd_wr ? reg_wdata[7:4] : UCC_MC_NONE;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         csel_reg <= UCC_CSEL_RESET;
         aux_reg  <= UCC_AUX_RESET;
      end
      else
      begin
         if (reg_wr && (reg_addr == UCC_OFS_CSEL))
            csel_reg <= reg_wdata;
         if (reg_wr && (reg_addr == UCC_OFS_AUX))
            aux_reg <= reg_wdata;
      end
   end

   // ************************************************************
   // Request to send
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         request_to_send_out_n <= 1'b1;
      else if (misc == UCC_MC_RTS_ON)
         request_to_send_out_n <= 1'b0;
      else if (misc == UCC_MC_RTS_OFF)
         request_to_send_out_n <= 1'b1;
   end

   // ************************************************************
   // Timeout mode and mode pointer
   // ************************************************************
   logic timeout_reg;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         timeout_reg <= 1'b0;
      else if (misc == UCC_MC_TMO_ON)
         timeout_reg <= 1'b1;
      else if (misc == UCC_MC_TMO_OFF)
         timeout_reg <= 1'b0;
   end

   assign ct_force_counter   = timeout_reg;
   assign ct_startstop_block = timeout_reg;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ct_halt        <= 1'b0;
         ct_ready_clear <= 1'b0;
         ct_restart     <= 1'b0;
         mode_ptr_zero  <= 1'b0;
      end
      else
      begin
         ct_halt        <= (misc == UCC_MC_TMO_ON);
         ct_ready_clear <= (misc == UCC_MC_TMO_ON);
         // Either receiver's transfer restarts the shared counter
         ct_restart     <= timeout_reg && (rx_xfer || peer_timeout_xfer);
         mode_ptr_zero  <= (misc == UCC_MC_MRP_ZERO);
      end
   end

   // ************************************************************
   // Error status
   // ************************************************************
   logic block_reg;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         block_reg <= 1'b0;
      else if (misc == UCC_MC_RX_RESET)
         block_reg <= 1'b0;
      else if (misc == UCC_MC_BLOCK_ERR)
         block_reg <= 1'b1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rx_err_status <= 4'h0;
      else if (block_reg)
      begin
         // A load in the clearing cycle still records its errors
         if (misc == UCC_MC_ERR_RESET || misc == UCC_MC_RX_RESET)
            rx_err_status <= rx_xfer ? rx_load_err : 4'h0;
         else if (rx_xfer)
            rx_err_status <= rx_err_status | rx_load_err;
      end
      else if (rx_queue_read)
         rx_err_status <= rx_head_err;
      else if (misc == UCC_MC_ERR_RESET || misc == UCC_MC_RX_RESET)
         rx_err_status <= 4'h0;
   end

   // ************************************************************
   // Receiver enable
   // ************************************************************
   logic rx_en_reg;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rx_en_reg <= 1'b0;
      else if (misc == UCC_MC_RX_RESET)
         rx_en_reg <= 1'b0;
      else if (cmd_wr && reg_wdata[UCC_CMD_RX_EN])
         rx_en_reg <= 1'b1;
      else if (cmd_wr && reg_wdata[UCC_CMD_RX_DIS])
         rx_en_reg <= 1'b0;
   end

   assign rx_active = rx_en_reg || wake_mode;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_abort <= 1'b0;
         rx_hunt  <= 1'b0;
         rx_reset <= 1'b0;
      end
      else
      begin
         rx_abort <= cmd_wr && reg_wdata[UCC_CMD_RX_DIS]
                     && !reg_wdata[UCC_CMD_RX_EN] && !wake_mode;
         rx_hunt  <= cmd_wr && reg_wdata[UCC_CMD_RX_EN] && !wake_mode;
         rx_reset <= (misc == UCC_MC_RX_RESET);
      end
   end

   // ************************************************************
   // Transmitter enable and flags
   // ************************************************************
   logic tx_en_reg;
   logic tx_pend_reg;
   logic tx_en_cmd;
   logic tx_dis_cmd;

   assign tx_en_cmd  = cmd_wr && reg_wdata[UCC_CMD_TX_EN];
   assign tx_dis_cmd = cmd_wr && reg_wdata[UCC_CMD_TX_DIS] && !reg_wdata[UCC_CMD_TX_EN];

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_en_reg   <= 1'b0;
         tx_pend_reg <= 1'b0;
      end
      else if (tx_en_cmd)
      begin
         tx_en_reg   <= 1'b1;
         tx_pend_reg <= 1'b0;
      end
      else if (tx_dis_cmd)
      begin
         tx_en_reg   <= 1'b0;
         tx_pend_reg <= !tx_idle;
      end
      else if (tx_pend_reg && tx_idle)
         tx_pend_reg <= 1'b0;
   end

   assign tx_active     = tx_en_reg || tx_pend_reg;
   assign txq_wr_accept = txq_wr_req && tx_en_reg;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         tx_space_available <= 1'b0;
      else if (tx_en_cmd)
         tx_space_available <= 1'b1;
      else if (tx_dis_cmd)
         tx_space_available <= 1'b0;
      else if (tx_en_reg && tx_space_set)
         tx_space_available <= 1'b1;
      else if (tx_space_clr)
         tx_space_available <= 1'b0;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         tx_underrun_flag <= 1'b0;
      else if (tx_en_cmd)
         tx_underrun_flag <= 1'b1;
      else if (tx_dis_cmd)
         tx_underrun_flag <= 1'b0;
      else if (tx_en_reg && tx_underrun_set)
         tx_underrun_flag <= 1'b1;
      else if (txq_wr_accept)
         tx_underrun_flag <= 1'b0;
   end

   // ************************************************************
   // Auxiliary pin synchronisers
   // ************************************************************
   logic [2:0] p2_sync;
   logic [2:0] p3_sync;
   logic       p2_lvl;
   logic       p3_lvl;
   logic       p2_rise;
   logic       p3_rise;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         p2_sync <= 3'h0;
         p3_sync <= 3'h0;
         p2_lvl  <= 1'b0;
         p3_lvl  <= 1'b0;
      end
      else
      begin
         p2_sync <= {p2_sync[1:0], aux_pin_two};
         p3_sync <= {p3_sync[1:0], aux_pin_three};
         if (p2_sync[1] == p2_sync[2])
            p2_lvl <= p2_sync[2];
         if (p3_sync[1] == p3_sync[2])
            p3_lvl <= p3_sync[2];
      end
   end

   assign p2_rise = (p2_sync[1] == p2_sync[2]) && p2_sync[2] && !p2_lvl;
   assign p3_rise = (p3_sync[1] == p3_sync[2]) && p3_sync[2] && !p3_lvl;

   // ************************************************************
   // Baud generators
   // ************************************************************
   logic [3:0]              rx_code;
   logic [3:0]              tx_code;
   logic [UCC_ACC_BITS-1:0] rx_acc;
   logic [UCC_ACC_BITS-1:0] tx_acc;
   logic [UCC_ACC_BITS:0]   rx_sum;
   logic [UCC_ACC_BITS:0]   tx_sum;

   assign rx_code = csel_reg[7:4];
   assign tx_code = csel_reg[3:0];
   assign rx_sum  = {1'b0, rx_acc}
                    + {1'b0, rate_step(aux_reg[UCC_AUX_GROUP], aux_reg[UCC_AUX_SET], rx_code)};
   assign tx_sum  = {1'b0, tx_acc}
                    + {1'b0, rate_step(aux_reg[UCC_AUX_GROUP], aux_reg[UCC_AUX_SET], tx_code)};

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_acc <= '0;
         tx_acc <= '0;
      end
      else
      begin
         rx_acc <= is_table(rx_code) ? rx_sum[UCC_ACC_BITS-1:0] : '0;
         tx_acc <= is_table(tx_code) ? tx_sum[UCC_ACC_BITS-1:0] : '0;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_clk_tick  <= 1'b0;
         rx_clk_is_1x <= 1'b0;
      end
      else
      begin
         rx_clk_is_1x <= (rx_code == UCC_CS_EXT1);
         case (rx_code)
            UCC_CS_TIMER: rx_clk_tick <= ct_16x_tick;
            UCC_CS_EXT16,
            UCC_CS_EXT1:  rx_clk_tick <= p2_rise;
            default:      rx_clk_tick <= rx_sum[UCC_ACC_BITS];
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_clk_tick  <= 1'b0;
         tx_clk_is_1x <= 1'b0;
      end
      else
      begin
         tx_clk_is_1x <= (tx_code == UCC_CS_EXT1);
         case (tx_code)
            UCC_CS_TIMER: tx_clk_tick <= ct_16x_tick;
            UCC_CS_EXT16,
            UCC_CS_EXT1:  tx_clk_tick <= p3_rise;
            default:      tx_clk_tick <= tx_sum[UCC_ACC_BITS];
         endcase
      end
   end

   // ************************************************************
   // Register reads
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= 8'h00;
      else if (reg_rd)
      begin
         case (reg_addr)
            UCC_OFS_STATUS: reg_rdata <= {rx_err_status, tx_underrun_flag,
                                          tx_space_available, tx_active, rx_active};
            UCC_OFS_AUX:    reg_rdata <= {aux_reg[7:3], block_reg, timeout_reg,
                                          !request_to_send_out_n};
            default:        reg_rdata <= 8'h00;
         endcase
      end
      else
         reg_rdata <= 8'h00;
   end

endmodule

// ---- rtl/ucc_pkg.sv ----
// Constants for one serial channel's command, clock select and status logic.
// Assumes a 125 MHz system clock and a 3.6864 MHz baud reference being emulated.
package ucc_pkg;

   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [1:0] UCC_OFS_CMD    = 2'h0;
   localparam logic [1:0] UCC_OFS_CSEL   = 2'h1;
   localparam logic [1:0] UCC_OFS_STATUS = 2'h2;
   localparam logic [1:0] UCC_OFS_AUX    = 2'h3;

   // ************************************************************
   // Field positions and reset values
   // ************************************************************
   localparam int UCC_CMD_RX_EN   = 0;
   localparam int UCC_CMD_RX_DIS  = 1;
   localparam int UCC_CMD_TX_EN   = 2;
   localparam int UCC_CMD_TX_DIS  = 3;
   localparam int UCC_AUX_SET     = 7;
   localparam int UCC_AUX_GROUP   = 0;
   localparam logic [7:0] UCC_CSEL_RESET = 8'h00;
   localparam logic [7:0] UCC_AUX_RESET  = 8'h00;

   // ************************************************************
   // Miscellaneous command codes
   // ************************************************************
   localparam logic [3:0] UCC_MC_NONE      = 4'h0;
   localparam logic [3:0] UCC_MC_RX_RESET  = 4'h2;
   localparam logic [3:0] UCC_MC_ERR_RESET = 4'h4;
   localparam logic [3:0] UCC_MC_RTS_ON    = 4'h8;
   localparam logic [3:0] UCC_MC_RTS_OFF   = 4'h9;
   localparam logic [3:0] UCC_MC_TMO_ON    = 4'ha;
   localparam logic [3:0] UCC_MC_MRP_ZERO  = 4'hb;
   localparam logic [3:0] UCC_MC_TMO_OFF   = 4'hc;
   localparam logic [3:0] UCC_MC_BLOCK_ERR = 4'hd;

   // ************************************************************
   // Clock select codes and rate table
   // ************************************************************
   localparam logic [3:0] UCC_CS_TIMER = 4'hd;
   localparam logic [3:0] UCC_CS_EXT16 = 4'he;
   localparam logic [3:0] UCC_CS_EXT1  = 4'hf;

   localparam longint UCC_CLK_HZ     = 125000000;
   localparam longint UCC_REF_HZ_X10 = 36864000;
   localparam int     UCC_ACC_BITS   = 32;

   // Baud rate times ten, index {group, set, code}, codes 0 to 12
   localparam int unsigned UCC_RATE_X10 [0:63] = '{
      500, 1100, 1345, 2000, 3000, 6000, 12000, 10500, 24000, 48000, 72000,
      96000, 384000, 0, 0, 0,
      750, 1100, 384000, 1500, 3000, 6000, 12000, 20000, 24000, 48000, 18000,
      96000, 192000, 0, 0, 0,
      3000, 1100, 1345, 12000, 18000, 36000, 72000, 10500, 144000, 288000,
      72000, 576000, 2304000, 0, 0, 0,
      4500, 1100, 1345, 9000, 18000, 36000, 72000, 20000, 144000, 288000,
      18000, 576000, 1152000, 0, 0, 0};

endpackage

// ---- verif/uart_channel_command_clock_select_tb_top.sv ----
// Self-checking bench for the channel command and clock select logic.
// Assumes the checker is bound in and the transmitter model stands beside.
module uart_channel_command_clock_select_tb_top;
   import ucc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct {logic [7:0] aux; logic [7:0] csel; int cyc; int rx; int tx;} ucc_row_type;
   ucc_row_type rows [4] = '{'{8'h81, 8'hcc, 678, 10, 10}, '{8'h01, 8'hc9, 2713, 80, 10},
                            '{8'h00, 8'hcc, 2035, 10, 10}, '{8'h80, 8'hc3, 4069, 10, 0}};

   logic       clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b1;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata;
   logic       aux_pin_two = 1'b0, aux_pin_three = 1'b0, wake_mode = 1'b0;
   logic       rx_xfer = 1'b0, rx_queue_read = 1'b0, peer_timeout_xfer = 1'b0;
   logic [3:0] rx_load_err = 4'h0, rx_head_err = 4'h0, rx_err_status;
   logic       tx_space_set = 1'b0, tx_space_clr = 1'b0, tx_underrun_set = 1'b0;
   logic       ct_16x_tick = 1'b0, txq_wr_req = 1'b0, tx_idle, request_to_send_out_n;
   logic       rx_active, rx_abort, rx_hunt, rx_reset, txq_wr_accept, tx_active;
   logic       tx_space_available, tx_underrun_flag, ct_restart, ct_halt, ct_ready_clear;
   logic       ct_force_counter, ct_startstop_block, mode_ptr_zero;
   logic       rx_clk_tick, rx_clk_is_1x, tx_clk_tick, tx_clk_is_1x;
   int         n_mismatch = 0, num_checks = 0, nrx = 0, ntx = 0, i;

   ucc_channel DUT (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .aux_pin_two, .aux_pin_three, .request_to_send_out_n, .wake_mode, .rx_xfer,
      .rx_load_err, .rx_queue_read, .rx_head_err, .rx_active, .rx_abort, .rx_hunt, .rx_reset,
      .rx_err_status, .tx_idle, .tx_space_set, .tx_space_clr, .tx_underrun_set, .txq_wr_req,
      .txq_wr_accept, .tx_active, .tx_space_available, .tx_underrun_flag, .peer_timeout_xfer,
      .ct_16x_tick, .ct_restart, .ct_halt, .ct_ready_clear, .ct_force_counter,
      .ct_startstop_block, .mode_ptr_zero, .rx_clk_tick, .rx_clk_is_1x, .tx_clk_tick,
      .tx_clk_is_1x);
   ucc_tx_peer u_peer (.clk, .rst_n, .slow, .txq_wr_accept, .tx_idle);

   always #4 clk = ~clk;

   always @(posedge clk)
   begin
      nrx += rx_clk_tick;
      ntx += tx_clk_tick;
   end

   // ********************************
   // Shared tasks
   // ********************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= w;
      reg_rd    <= !w;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
      #1;
   endtask

   task automatic cmd(input logic [7:0] d);
      repeat (3) @(posedge clk);
      bus(1'b1, UCC_OFS_CMD, d);
   endtask

   task automatic strobe(input int sel, input logic [3:0] e);
      @(posedge clk);
      rx_xfer           <= (sel == 0);
      rx_queue_read     <= (sel == 1);
      peer_timeout_xfer <= (sel == 2);
      rx_load_err       <= e;
      rx_head_err       <= e;
      @(posedge clk);
      rx_xfer           <= 1'b0;
      rx_queue_read     <= 1'b0;
      peer_timeout_xfer <= 1'b0;
      #1;
   endtask

   task automatic reset_dut;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      #1;
   endtask

   // ********************************
   // Main sequence
   // ********************************
   initial
   begin
      reset_dut();
      check({4'h0, request_to_send_out_n, tx_space_available, txq_wr_accept, rx_clk_is_1x},
            8'h08);
      for (i = 0; i < 4; i++)
      begin
         bus(1'b1, UCC_OFS_AUX, rows[i].aux);
         bus(1'b1, UCC_OFS_CSEL, rows[i].csel);
         nrx = 0;
         ntx = 0;
         repeat (rows[i].cyc) @(posedge clk);
         #1;
         check({6'h00, rx_clk_is_1x, nrx >= rows[i].rx - 1 && nrx <= rows[i].rx + 1},
               8'h01);
         check({6'h00, tx_clk_is_1x, ntx >= rows[i].tx - 1 && ntx <= rows[i].tx + 1},
               8'h01);
      end
      bus(1'b1, UCC_OFS_CSEL, 8'hfe);
      nrx = 0;
      ntx = 0;
      repeat (5)
      begin
         aux_pin_two   <= 1'b1;
         aux_pin_three <= 1'b1;
         repeat (8) @(posedge clk);
         aux_pin_two   <= 1'b0;
         aux_pin_three <= 1'b0;
         repeat (8) @(posedge clk);
      end
      #1;
      check({6'h00, rx_clk_is_1x, tx_clk_is_1x}, 8'h02);
      check({4'(nrx), 4'(ntx)}, 8'h55);
      bus(1'b1, UCC_OFS_CSEL, 8'hff);
      @(posedge clk);
      #1;
      check({6'h00, rx_clk_is_1x, tx_clk_is_1x}, 8'h03);
      // Timer code passes the counter/timer 16X tick straight through
      bus(1'b1, UCC_OFS_CSEL, 8'hdd);
      nrx = 0;
      ntx = 0;
      repeat (4)
      begin
         @(posedge clk);
         ct_16x_tick <= ~ct_16x_tick;
      end
      repeat (2) @(posedge clk);
      #1;
      check({4'(nrx), 4'(ntx)}, 8'h22);
      // Command field and enable bits in one write
      cmd(8'h85);
      check({5'h00, request_to_send_out_n, rx_hunt, tx_space_available}, 8'h03);
      cmd(8'h02);
      check({6'h00, rx_abort, rx_active}, 8'h02);
      cmd(8'h00);
      check({6'h00, request_to_send_out_n, tx_active}, 8'h01);
      cmd(8'h90);
      check({7'h00, request_to_send_out_n}, 8'h01);
      wake_mode <= 1'b1;
      cmd(8'h03);
      check({5'h00, rx_abort, rx_hunt, rx_active}, 8'h01);
      wake_mode <= 1'b0;
      // Timeout mode
      cmd(8'ha0);
      check({4'h0, ct_halt, ct_ready_clear, ct_force_counter, ct_startstop_block}, 8'h0f);
      bus(1'b0, UCC_OFS_AUX, 8'h00);
      check(reg_rdata, 8'h82);
      strobe(0, 4'h0);
      check({7'h00, ct_restart}, 8'h01);
      strobe(2, 4'h0);
      check({7'h00, ct_restart}, 8'h01);
      cmd(8'hc0);
      check({5'h00, ct_force_counter, ct_halt, ct_ready_clear}, 8'h00);
      strobe(0, 4'h0);
      check({7'h00, ct_restart}, 8'h00);
      cmd(8'hb0);
      check({7'h00, mode_ptr_zero}, 8'h01);
      // Error status, per character then block
      strobe(1, 4'h6);
      check({4'h0, rx_err_status}, 8'h06);
      cmd(8'h40);
      cmd(8'hd0);
      strobe(0, 4'h1);
      strobe(0, 4'h8);
      strobe(1, 4'h2);
      check({4'h0, rx_err_status}, 8'h09);
      cmd(8'h20);
      check({7'h00, rx_reset}, 8'h01);
      strobe(1, 4'h3);
      check({4'h0, rx_err_status}, 8'h03);
      cmd(8'hd0);
      reset_dut();
      strobe(1, 4'h5);
      check({4'h0, rx_err_status}, 8'h05);
      // Transmitter enable, queue, disable with drain
      cmd(8'h04);
      check({6'h00, tx_space_available, tx_underrun_flag}, 8'h03);
      bus(1'b1, UCC_OFS_STATUS, 8'hff);
      bus(1'b0, UCC_OFS_STATUS, 8'h00);
      check(reg_rdata, 8'h5e);
      bus(1'b0, UCC_OFS_CMD, 8'h00);
      check(reg_rdata, 8'h00);
      txq_wr_req <= 1'b1;
      repeat (2) @(posedge clk);
      txq_wr_req <= 1'b0;
      cmd(8'h08);
      check({5'h00, tx_space_available, tx_underrun_flag, tx_active}, 8'h01);
      txq_wr_req <= 1'b1;
      @(posedge clk);
      #1;
      check({7'h00, txq_wr_accept}, 8'h00);
      for (i = 0; i < 200 && tx_active === 1'b1; i++)
         @(posedge clk);
      txq_wr_req <= 1'b0;
      if (i == 200)
         n_mismatch++;
      #1;
      check({7'h00, tx_idle}, 8'h01);
      print_verdict();
   end
endmodule

// ---- verif/ucc_channel_properties.sv ----
// Concurrent checks on the ports of the channel command logic.
// Assumes one clock domain and binding onto ucc_channel.
module ucc_channel_properties
   import ucc_pkg::*;
(
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // Register port and stimulus
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       wake_mode,
   input wire logic       rx_xfer,
   input wire logic       peer_timeout_xfer,
   input wire logic       tx_idle,
   // Observed outputs
   input wire logic       request_to_send_out_n,
   input wire logic       rx_active,
   input wire logic       rx_abort,
   input wire logic       rx_hunt,
   input wire logic       txq_wr_accept,
   input wire logic       tx_active,
   input wire logic       tx_space_available,
   input wire logic       tx_underrun_flag,
   input wire logic       ct_restart,
   input wire logic       ct_halt,
   input wire logic       ct_ready_clear,
   input wire logic       ct_force_counter,
   input wire logic       ct_startstop_block,
   input wire logic       mode_ptr_zero
);
   wire logic       cmd_wr = reg_wr && (reg_addr == UCC_OFS_CMD);
   wire logic [3:0] code   = reg_wdata[7:4];
   wire logic       tx_off = cmd_wr && reg_wdata[3] && !reg_wdata[2];

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   chk_rts_negate: assert property (cmd_wr && code == 4'h9 |=> request_to_send_out_n)
      else $error("request to send not negated");
   chk_rts_assert: assert property (cmd_wr && code == 4'h8 |=> !request_to_send_out_n)
      else $error("request to send not asserted");
   chk_tmo_enter: assert property (cmd_wr && code == 4'ha |=> ct_halt && ct_ready_clear
      && ct_force_counter && ct_startstop_block) else $error("timeout entry incomplete");
   chk_tmo_restart: assert property (ct_force_counter && (rx_xfer || peer_timeout_xfer)
      |=> ct_restart) else $error("counter not restarted");
   chk_tmo_leave: assert property (cmd_wr && code == 4'hc |=> !ct_force_counter
      && !ct_startstop_block && !ct_halt && !ct_ready_clear) else $error("timeout exit wrong");
   chk_ptr_zero: assert property (cmd_wr && code == 4'hb |=> mode_ptr_zero)
      else $error("mode pointer not reset");
   chk_tx_enable: assert property (cmd_wr && reg_wdata[2] |=> tx_space_available
      && tx_underrun_flag && tx_active) else $error("transmitter enable flags wrong");
   chk_tx_disable: assert property (tx_off |=> !tx_space_available && !tx_underrun_flag
      && !txq_wr_accept) else $error("transmitter disable flags wrong");
   chk_tx_drain: assert property (tx_off && tx_active && !tx_idle |=> tx_active)
      else $error("transmitter stopped before draining");
   chk_txq_refuse: assert property (!tx_active |-> !txq_wr_accept)
      else $error("queue write taken while disabled");
   chk_rx_abort: assert property (cmd_wr && reg_wdata[1] && !reg_wdata[0] && !wake_mode
      |=> rx_abort && !rx_active) else $error("receiver not stopped");
   chk_rx_hunt: assert property (cmd_wr && reg_wdata[0] && !wake_mode |=> rx_hunt)
      else $error("receiver not hunting");
   chk_wake_run: assert property (wake_mode |-> rx_active)
      else $error("receiver halted in wake mode");
endmodule

bind ucc_channel ucc_channel_properties u_chk (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
   .wake_mode, .rx_xfer, .peer_timeout_xfer, .tx_idle, .request_to_send_out_n, .rx_active,
   .rx_abort, .rx_hunt, .txq_wr_accept, .tx_active, .tx_space_available, .tx_underrun_flag,
   .ct_restart, .ct_halt, .ct_ready_clear, .ct_force_counter, .ct_startstop_block,
   .mode_ptr_zero);

// ---- verif/ucc_tx_peer.sv ----
// Behavioural transmitter beside the channel: holds accepted characters.
// Assumes one accept per cycle; drains one character per period.
module ucc_tx_peer
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Channel side
   input  wire logic slow,
   input  wire logic txq_wr_accept,
   output logic      tx_idle
);
   int unsigned held;
   int unsigned timer;

   // Each held character is sent in full before the queue counts empty
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         held  <= 0;
         timer <= 0;
      end
      else if (held != 0 && timer >= (slow ? 40 : 4))
      begin
         held  <= held - 1 + txq_wr_accept;
         timer <= 0;
      end
      else
      begin
         held  <= held + txq_wr_accept;
         timer <= (held != 0) ? timer + 1 : 0;
      end
   end

   assign tx_idle = (held == 0);
endmodule
